// ### common/fesr_pkg.sv
`default_nettype none

package fesr_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int RSRC_W = 8;

    // ----------------------------------------------------------------
    // memory variants and their code space limits
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        VAR_LARGE = 2'b00,
        VAR_MID = 2'b01,
        VAR_SMALL = 2'b10
    } fesr_variant_e;

    localparam logic [ADDR_W-1:0] LIMIT_LARGE = 16'h1DFF;
    localparam logic [ADDR_W-1:0] LIMIT_MID = 16'h0FFF;
    localparam logic [ADDR_W-1:0] LIMIT_SMALL = 16'h07FF;
    localparam logic [ADDR_W-1:0] RESET_VECTOR = 16'h0000;

    // ----------------------------------------------------------------
    // reset source register layout
    // ----------------------------------------------------------------
    localparam int BIT_PIN = 0;
    localparam int BIT_MCD = 2;
    localparam int BIT_SWRST = 4;
    localparam int BIT_FERR = 6;
    localparam logic [RSRC_W-1:0] RSRC_RESET = 8'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESET_DELAY_NS = 5000;
    localparam int PIN_LOW_NS = 15000;
    localparam int MCD_MIN_NS = 100000;
    localparam int MCD_TYP_NS = 220000;
    localparam int MCD_MAX_NS = 500000;
    localparam int DLY_CYCLES =
        (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIN_CYCLES =
        (PIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MCD_MIN_CYCLES =
        (MCD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MCD_TYP_CYCLES = MCD_TYP_NS / CLK_PERIOD_NS;
    localparam int MCD_MAX_CYCLES = MCD_MAX_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HOLD = 2'b01,
        ST_DELAY = 2'b10
    } fesr_state_e;

endpackage

`default_nettype wire

// ### rtl/fesr_timer.sv
`timescale 1ns/1ps
`default_nettype none

module fesr_timer #(
    parameter int LIMIT = 4
) (
    input wire logic i_clock, // system clock
    input wire logic i_rst_n, // synchronous reset, active low
    input wire logic i_run, // count while high, clear while low
    output logic o_done // high once i_run held LIMIT cycles
);
    import fesr_pkg::*;

    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] TOP = W'(LIMIT - 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } fesr_timer_s;

    fesr_timer_s st_reg;
    fesr_timer_s st_next;

    always_comb begin
        st_next = st_reg;
        if (!i_run) begin
            st_next.cnt = '0;
            st_next.done = 1'b0;
        end else if (st_reg.cnt == TOP) begin
            // saturate: done stays up while i_run holds
            st_next.done = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_done = st_reg.done;

endmodule

`default_nettype wire

// ### rtl/fesr_top.sv
// Summary of operation
// - write-enabled external move above code limit resets, write not done
// - code move read above the code limit causes a system reset
// - instruction fetch above the code limit causes a system reset
// - code limit fixed per variant: 0x1DFF, 0x0FFF or 0x07FF
// - flash error flag at bit 6 reads set after a flash error reset
// - writing one to bit 4 forces an immediate system reset
// - bit 4 reads one after a software forced reset
// - flash error and software resets never drive the reset pin
// - at least 5.0 us from source release to execution at 0x0000
// - missing clock reset starts 100 to 500 us after last clock edge
`timescale 1ns/1ps
`default_nettype none

module fesr_top #(
    parameter fesr_pkg::fesr_variant_e VARIANT = fesr_pkg::VAR_LARGE,
    parameter int MCD_CYCLES = fesr_pkg::MCD_TYP_CYCLES,
    parameter int PIN_LOW_CYCLES = fesr_pkg::PIN_CYCLES,
    parameter int DELAY_CYCLES = fesr_pkg::DLY_CYCLES
) (
    input wire logic i_clock, // 50 MHz reference clock
    input wire logic i_rst_n, // power-on reset, sync, active low
    input wire logic i_flash_write_enable_flag, // core flash write enable
    input wire logic i_ext_move_valid, // external move write/erase
    input wire logic [fesr_pkg::ADDR_W-1:0] i_ext_move_addr, // its target
    input wire logic i_code_move_valid, // code move (table) read
    input wire logic [fesr_pkg::ADDR_W-1:0] i_code_move_addr, // its target
    input wire logic i_fetch_valid, // fetch after a branch
    input wire logic [fesr_pkg::ADDR_W-1:0] i_fetch_addr, // fetch target
    input wire logic i_rsrc_wr, // write strobe, reset source register
    input wire logic [fesr_pkg::RSRC_W-1:0] i_rsrc_wdata, // write data
    input wire logic i_rst_pin_n, // external reset pin level, async
    input wire logic i_sysclk_mon, // monitored system clock, async
    output logic o_core_rst_n, // core held in reset while low
    output logic [fesr_pkg::ADDR_W-1:0] o_start_addr, // first fetch
    output logic o_flash_wr_go, // legal flash write may proceed
    output logic [fesr_pkg::RSRC_W-1:0] o_rsrc_rdata, // reset causes
    output logic o_rst_pin_out, // reset pin drive level
    output logic o_rst_pin_oe // reset pin driven while high
);
    import fesr_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        fesr_state_e fsm;
        logic pin_s1;
        logic pin_s2;
        logic mon_s1;
        logic mon_s2;
        logic mon_s3;
        logic [RSRC_W-1:0] flags;
        logic core_rst_n;
        logic wr_go;
        logic pin_oe;
        logic pin_out;
        logic [ADDR_W-1:0] start_addr;
    } fesr_top_s;

    localparam fesr_top_s ST_RESET = '{
        fsm: ST_DELAY,
        pin_s1: 1'b1,
        pin_s2: 1'b1,
        mon_s1: 1'b0,
        mon_s2: 1'b0,
        mon_s3: 1'b0,
        flags: RSRC_RESET,
        core_rst_n: 1'b0,
        wr_go: 1'b0,
        pin_oe: 1'b0,
        pin_out: 1'b0,
        start_addr: RESET_VECTOR
    };

    fesr_top_s s_reg;
    fesr_top_s s_next;

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] limit_of(fesr_variant_e v);
        case (v)
            VAR_LARGE: limit_of = LIMIT_LARGE;
            VAR_MID: limit_of = LIMIT_MID;
            VAR_SMALL: limit_of = LIMIT_SMALL;
            default: limit_of = LIMIT_SMALL;
        endcase
    endfunction

    localparam logic [ADDR_W-1:0] LIMIT = limit_of(VARIANT);

    // strictly greater: the limit address itself is still user code
    function automatic logic above(logic [ADDR_W-1:0] a);
        above = (a > LIMIT);
    endfunction

    // one-hot cause; pin and missing clock outrank core-side causes
    function automatic logic [RSRC_W-1:0] cause_of(
        logic pin, logic mcd, logic ferr, logic sw
    );
        cause_of = RSRC_RESET;
        if (pin) begin
            cause_of[BIT_PIN] = 1'b1;
        end else if (mcd) begin
            cause_of[BIT_MCD] = 1'b1;
        end else if (ferr) begin
            cause_of[BIT_FERR] = 1'b1;
        end else if (sw) begin
            cause_of[BIT_SWRST] = 1'b1;
        end
    endfunction

    // ----------------------------------------------------------------
    // reset sources
    // ----------------------------------------------------------------
    logic pin_evt;
    logic mcd_evt;
    logic dly_done;
    logic mon_edge;
    logic wr_bad;
    logic ferr_evt;
    logic sw_evt;
    logic hw_evt;

    assign mon_edge = s_reg.mon_s2 & ~s_reg.mon_s3;
    assign wr_bad = i_ext_move_valid & i_flash_write_enable_flag
                    & above(i_ext_move_addr);
    assign ferr_evt = wr_bad
                      | (i_code_move_valid & above(i_code_move_addr))
                      | (i_fetch_valid & above(i_fetch_addr));
    assign sw_evt = i_rsrc_wr & i_rsrc_wdata[BIT_SWRST];
    assign hw_evt = pin_evt | mcd_evt;

    // glitches shorter than the low time are not a reset request
    fesr_timer #(
        .LIMIT(PIN_LOW_CYCLES)
    ) u_pin_filter (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_run(~s_reg.pin_s2),
        .o_done(pin_evt)
    );

    // restarted by every rising edge of the monitored clock
    fesr_timer #(
        .LIMIT(MCD_CYCLES)
    ) u_mcd (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_run(~mon_edge),
        .o_done(mcd_evt)
    );

    fesr_timer #(
        .LIMIT(DELAY_CYCLES)
    ) u_release (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_run(s_reg.fsm == ST_DELAY),
        .o_done(dly_done)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.pin_s1 = i_rst_pin_n;
        s_next.pin_s2 = s_reg.pin_s1;
        s_next.mon_s1 = i_sysclk_mon;
        s_next.mon_s2 = s_reg.mon_s1;
        s_next.mon_s3 = s_reg.mon_s2;
        s_next.wr_go = 1'b0;
        s_next.pin_out = 1'b0;
        case (s_reg.fsm)
            ST_RUN: begin
                if (hw_evt | ferr_evt | sw_evt) begin
                    s_next.fsm = ST_HOLD;
                    s_next.flags = cause_of(pin_evt, mcd_evt,
                                            ferr_evt, sw_evt);
                end else begin
                    // illegal writes never reach the flash
                    s_next.wr_go = i_ext_move_valid
                                   & i_flash_write_enable_flag;
                end
            end
            ST_HOLD: begin
                if (hw_evt) begin
                    s_next.flags = cause_of(pin_evt, mcd_evt,
                                            1'b0, 1'b0);
                end else begin
                    s_next.fsm = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (hw_evt) begin
                    s_next.fsm = ST_HOLD;
                    s_next.flags = cause_of(pin_evt, mcd_evt,
                                            1'b0, 1'b0);
                end else if (dly_done) begin
                    s_next.fsm = ST_RUN;
                    s_next.start_addr = RESET_VECTOR;
                end
            end
            default: begin
                s_next.fsm = ST_DELAY;
            end
        endcase
        s_next.core_rst_n = (s_next.fsm == ST_RUN);
        // only the missing clock reset pulls the pin; internal
        // flash and software resets leave it alone
        s_next.pin_oe = (s_next.fsm == ST_HOLD)
                        & s_next.flags[BIT_MCD];
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            s_reg <= ST_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_core_rst_n = s_reg.core_rst_n;
    assign o_start_addr = s_reg.start_addr;
    assign o_flash_wr_go = s_reg.wr_go;
    assign o_rsrc_rdata = s_reg.flags;
    assign o_rst_pin_out = s_reg.pin_out;
    assign o_rst_pin_oe = s_reg.pin_oe;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    int low_cnt;
    int idle_cnt;
    logic run_q;
    logic quiet;

    assign run_q = (s_reg.fsm == ST_RUN);
    assign quiet = run_q & ~hw_evt;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n || o_core_rst_n) begin
            low_cnt <= 0;
        end else if (low_cnt < DELAY_CYCLES + 2) begin
            low_cnt <= low_cnt + 1;
        end
        if (!i_rst_n || mon_edge) begin
            idle_cnt <= 0;
        end else if (idle_cnt <= MCD_CYCLES) begin
            idle_cnt <= idle_cnt + 1;
        end
    end

    property p_wr_rst;
        quiet && wr_bad |=> !o_core_rst_n && !o_flash_wr_go;
    endproperty
    a_wr_rst: assert property (p_wr_rst)
        else $error("illegal flash write did not reset");

    property p_cmove_rst;
        quiet && i_code_move_valid && above(i_code_move_addr)
            |=> !o_core_rst_n ##1 !o_core_rst_n;
    endproperty
    a_cmove_rst: assert property (p_cmove_rst)
        else $error("illegal code move did not reset");

    property p_fetch_rst;
        quiet && i_fetch_valid && above(i_fetch_addr) |=> !o_core_rst_n;
    endproperty
    a_fetch_rst: assert property (p_fetch_rst)
        else $error("illegal fetch did not reset");

    property p_limit;
        quiet && i_fetch_valid && i_fetch_addr == LIMIT + 16'h0001
            |=> !o_core_rst_n;
    endproperty
    a_limit: assert property (p_limit)
        else $error("fetch one past the limit did not reset");

    property p_ferr_flag;
        quiet && ferr_evt |=> o_rsrc_rdata[BIT_FERR]
            && !o_rsrc_rdata[BIT_SWRST] [*8];
    endproperty
    a_ferr_flag: assert property (p_ferr_flag)
        else $error("flash error flag not set");

    property p_sw_rst;
        quiet && !ferr_evt && sw_evt |=> !o_core_rst_n [*8];
    endproperty
    a_sw_rst: assert property (p_sw_rst)
        else $error("software reset not taken");

    property p_sw_flag;
        quiet && !ferr_evt && sw_evt
            |=> o_rsrc_rdata[BIT_SWRST] && !o_rsrc_rdata[BIT_FERR];
    endproperty
    a_sw_flag: assert property (p_sw_flag)
        else $error("software reset flag not set");

    property p_pin_quiet;
        o_rsrc_rdata[BIT_FERR] || o_rsrc_rdata[BIT_SWRST]
            |-> !o_rst_pin_oe;
    endproperty
    a_pin_quiet: assert property (p_pin_quiet)
        else $error("internal reset drove the reset pin");

    property p_release;
        $rose(o_core_rst_n) |-> $past(low_cnt) >= DELAY_CYCLES
            && o_start_addr == RESET_VECTOR;
    endproperty
    a_release: assert property (p_release)
        else $error("execution started too early");

    property p_mcd;
        $rose(mcd_evt) |-> idle_cnt == MCD_CYCLES
            && idle_cnt >= MCD_MIN_CYCLES && idle_cnt <= MCD_MAX_CYCLES;
    endproperty
    a_mcd: assert property (p_mcd)
        else $error("missing clock timeout wrong");

    property p_at_limit;
        quiet && !sw_evt && !(i_ext_move_valid || i_code_move_valid)
            && i_fetch_valid && i_fetch_addr == LIMIT |=> o_core_rst_n;
    endproperty
    a_at_limit: assert property (p_at_limit)
        else $error("fetch at the limit reset the core");

    c_ferr: cover property (quiet && ferr_evt ##1 !o_core_rst_n);
    c_sw: cover property (quiet && sw_evt ##1 !o_core_rst_n);
    c_pin: cover property ($rose(pin_evt));
    c_release: cover property ($rose(o_core_rst_n));

endmodule

`default_nettype wire

// ### test/fesr_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module fesr_core_model (
    input wire logic i_clock, // system clock
    output logic o_write_enable, // flash write enable level
    output logic o_ext_valid, // external move pulse
    output logic [fesr_pkg::ADDR_W-1:0] o_ext_addr, // its target
    output logic o_code_valid, // code move pulse
    output logic [fesr_pkg::ADDR_W-1:0] o_code_addr, // its target
    output logic o_fetch_valid, // branch fetch pulse
    output logic [fesr_pkg::ADDR_W-1:0] o_fetch_addr, // its target
    output logic o_rsrc_wr, // reset source write strobe
    output logic [fesr_pkg::RSRC_W-1:0] o_rsrc_wdata // its data
);
    import fesr_pkg::*;

    initial begin
        {o_write_enable, o_ext_valid, o_code_valid} = 3'h0;
        {o_fetch_valid, o_rsrc_wr} = 2'h0;
        o_ext_addr = 16'h0000;
        o_code_addr = 16'h0000;
        o_fetch_addr = 16'h0000;
        o_rsrc_wdata = 8'h00;
    end

    // kind 0 enabled ext move, 1 ext move without enable,
    // 2 code move, 3 fetch, 4 reset source write
    task automatic access(input int kind, input logic [ADDR_W-1:0] addr,
        input logic [RSRC_W-1:0] wdata);
        @(negedge i_clock);
        o_write_enable = (kind == 0);
        o_ext_valid = (kind < 2);
        o_code_valid = (kind == 2);
        o_fetch_valid = (kind == 3);
        o_rsrc_wr = (kind == 4);
        o_ext_addr = addr;
        o_code_addr = addr;
        o_fetch_addr = addr;
        o_rsrc_wdata = wdata;
        @(negedge i_clock);
        // idle buses flip so a stale address can never look valid
        {o_ext_valid, o_code_valid, o_fetch_valid, o_rsrc_wr} = 4'h0;
        o_write_enable = 1'b0;
        o_ext_addr = ~addr;
        o_code_addr = ~addr;
        o_fetch_addr = ~addr;
        o_rsrc_wdata = ~wdata;
    endtask
endmodule

`default_nettype wire

// ### test/fesr_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module fesr_tb_top;
    import fesr_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] LIMS [3] =
        '{LIMIT_LARGE, LIMIT_MID, LIMIT_SMALL};
    localparam logic [ADDR_W-1:0] EDGES [8] = '{16'h07FF, 16'h0800,
        16'h0FFF, 16'h1000, 16'h1DFF, 16'h1E00, 16'hFFFF, 16'h0000};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic pin_n = 1'b1;
    logic mon = 1'b0;
    logic mon_run = 1'b1;
    logic we, ext_v, code_v, fetch_v, rsrc_wr;
    logic [ADDR_W-1:0] ext_a, code_a, fetch_a;
    logic [RSRC_W-1:0] wdata;
    logic [2:0] core_rst_n, go, pin_out, pin_oe;
    logic [ADDR_W-1:0] start_addr [3];
    logic [RSRC_W-1:0] rdata [3];
    logic [RSRC_W-1:0] exp_flag [3];
    int exp_go [3], go_cnt [3], oe_cnt [3], low_len [3], last_low [3];
    int num_errors = 0;
    int checks = 0;

    always #10 clock = ~clock;
    // monitored clock halts entirely when stopped, as a dead source would
    always @(negedge clock) if (mon_run) mon <= ~mon;

    fesr_core_model core (.i_clock(clock), .o_write_enable(we),
        .o_ext_valid(ext_v), .o_ext_addr(ext_a), .o_code_valid(code_v),
        .o_code_addr(code_a), .o_fetch_valid(fetch_v),
        .o_fetch_addr(fetch_a), .o_rsrc_wr(rsrc_wr), .o_rsrc_wdata(wdata));

    for (genvar g = 0; g < 3; g++) begin : g_dut
        fesr_top #(.VARIANT(fesr_variant_e'(g))) DUT (
            .i_clock(clock),
            .i_rst_n(rst_n),
            .i_flash_write_enable_flag(we),
            .i_ext_move_valid(ext_v),
            .i_ext_move_addr(ext_a),
            .i_code_move_valid(code_v),
            .i_code_move_addr(code_a),
            .i_fetch_valid(fetch_v),
            .i_fetch_addr(fetch_a),
            .i_rsrc_wr(rsrc_wr),
            .i_rsrc_wdata(wdata),
            .i_rst_pin_n(pin_n),
            .i_sysclk_mon(mon),
            .o_core_rst_n(core_rst_n[g]),
            .o_start_addr(start_addr[g]),
            .o_flash_wr_go(go[g]),
            .o_rsrc_rdata(rdata[g]),
            .o_rst_pin_out(pin_out[g]),
            .o_rst_pin_oe(pin_oe[g])
        );
    end

    always @(posedge clock) begin
        for (int v = 0; v < 3; v++) begin
            if (go[v] === 1'b1) go_cnt[v]++;
            if (pin_oe[v] === 1'b1) oe_cnt[v]++;
            if (core_rst_n[v] === 1'b0) begin
                low_len[v]++;
            end else begin
                if (low_len[v] > 0) last_low[v] = low_len[v];
                low_len[v] = 0;
            end
        end
    end

    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask

    task automatic end_of_test;
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wait_run;
        int n;
        n = 0;
        while (core_rst_n !== 3'b111 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        cmp(16'(core_rst_n), 16'h0007);
    endtask

    task automatic access(input int kind, input logic [15:0] addr,
        input logic [7:0] wd);
        logic [2:0] hit;
        logic over;
        hit = 3'b000;
        for (int v = 0; v < 3; v++) begin
            over = addr > LIMS[v];
            hit[v] = (kind == 4) ? wd[BIT_SWRST] : (over && kind != 1);
            if (hit[v]) begin
                exp_flag[v] = RSRC_RESET;
                exp_flag[v][(kind == 4) ? BIT_SWRST : BIT_FERR] = 1'b1;
            end
            if (kind == 0 && !over) exp_go[v]++;
        end
        core.access(kind, addr, wd);
        repeat (2) @(negedge clock);
        for (int v = 0; v < 3; v++) begin
            cmp(16'(core_rst_n[v]),
                16'(!hit[v]));
            cmp(16'(rdata[v]), 16'(exp_flag[v]));
            cmp(16'(go_cnt[v]), 16'(exp_go[v]));
            cmp(16'(oe_cnt[v]), 16'h0000);
            cmp(16'(pin_out[v]), 16'h0000);
        end
        if (hit != 3'b000) begin
            wait_run;
            // low length is latched one edge after the release
            @(negedge clock);
            for (int v = 0; v < 3; v++) begin
                if (hit[v]) begin
                    cmp(start_addr[v], RESET_VECTOR);
                    cmp(16'(last_low[v] >= DLY_CYCLES), 16'h0001);
                end
            end
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] a;
        logic [7:0] w;
        int n;
        void'($urandom(32'h99FF261A));
        for (int v = 0; v < 3; v++) begin
            exp_flag[v] = RSRC_RESET;
            exp_go[v] = 0;
        end
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        wait_run;
        for (int v = 0; v < 3; v++) begin
            cmp(16'(rdata[v]), 16'(RSRC_RESET));
            cmp(start_addr[v], RESET_VECTOR);
        end
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 5; k++) begin
                a = (i < 8) ? EDGES[i] : 16'($urandom);
                w = 8'($urandom);
                if (i < 8) w[4] = i[0];
                access(k, a, w);
            end
        end
        // a pulse short of the minimum must be ignored
        pin_n = 1'b0;
        repeat (PIN_CYCLES - 100) @(negedge clock);
        pin_n = 1'b1;
        repeat (10) @(negedge clock);
        cmp(16'(core_rst_n), 16'h0007);
        pin_n = 1'b0;
        repeat (PIN_CYCLES + 20) @(negedge clock);
        cmp(16'(core_rst_n), 16'h0000);
        for (int v = 0; v < 3; v++) begin
            cmp(16'(rdata[v]), 16'(1 << BIT_PIN));
        end
        pin_n = 1'b1;
        wait_run;
        mon_run = 1'b0;
        repeat (MCD_MIN_CYCLES - 10) @(negedge clock);
        cmp(16'(core_rst_n), 16'h0007);
        n = 0;
        // the stop already lasted MCD_MIN_CYCLES - 10 cycles
        while (core_rst_n !== 3'b000
               && n < MCD_MAX_CYCLES - MCD_MIN_CYCLES + 10) begin
            @(negedge clock);
            n++;
        end
        cmp(16'(core_rst_n), 16'h0000);
        cmp(16'(pin_oe), 16'h0007);
        cmp(16'(pin_out), 16'h0000);
        for (int v = 0; v < 3; v++) begin
            cmp(16'(rdata[v]), 16'(1 << BIT_MCD));
        end
        mon_run = 1'b1;
        wait_run;
        end_of_test;
    end

    initial begin
        #(1_200_000);
        num_errors++;
        end_of_test;
    end
endmodule

`default_nettype wire
